// File: hdl/tvc_pkg.sv
// constants for the thruster and valve command logic
package tvc_pkg;
   localparam int CMD_BITS        = 37;
   localparam int NUM_ENG         = 12;
   localparam int NUM_VALVE       = 7;
   localparam int TC_LSB          = 0;
   localparam int XFER_BIT        = 12;
   localparam int EN_LSB          = 13;
   localparam int VALVE_LSB       = 25;
   localparam int LARGE_PULSE_BIT = 32;
   localparam int PRIMARY_BIT     = 33;
   localparam int ACCEL_BIT       = 34;
   localparam int PHASE_BIT       = 35;
   localparam int SMALL_PULSE_BIT = 36;
   localparam logic [11:0] LARGE_ENG_MASK = 12'h492;
   localparam logic [11:0] PN_ENG_MASK    = 12'h410;
   localparam int PULSE_MS        = 100;
   localparam int CLK_MHZ         = 100;
   localparam int PULSE_CYC       = PULSE_MS * 1000 * CLK_MHZ;
endpackage

// File: hdl/tvc_link_if.sv
// carrier for a received command word
`timescale 1ns/1ps
interface tvc_link_if;
   logic [36:0] word;
   logic        done;
   modport rx   (output word, output done);
   modport core (input word, input done);
endinterface

// File: hdl/tvc_serial_rx.sv
// serial command word receiver on the system clock
`timescale 1ns/1ps
module tvc_serial_rx
   import tvc_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic link_clk,
   input  wire logic link_data,
   input  wire logic link_gate,
   tvc_link_if.rx    lnk
);
   logic [2:0]  s1_ff, s2_ff, s3_ff;
   logic [36:0] sr_ff, nxt_sr;
   logic [5:0]  cnt_ff, nxt_cnt;
   logic        done_ff, nxt_done;
   logic        clk_fall, gate_rise, gate_fall;

   ////////////////////////////////////////////////////////////////////
   // two-stage synchronisers then edge history
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_ff <= 3'h0;
         s2_ff <= 3'h0;
         s3_ff <= 3'h0;
      end else begin
         s1_ff <= {link_gate, link_data, link_clk};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign clk_fall  = s3_ff[0] & ~s2_ff[0];
   assign gate_rise = ~s3_ff[2] & s2_ff[2];
   assign gate_fall = s3_ff[2] & ~s2_ff[2];

   ////////////////////////////////////////////////////////////////////
   // shift on the trailing clock edge inside the gate, first bit lands low
   always_comb begin
      nxt_sr   = sr_ff;
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (gate_rise) begin
         nxt_cnt = 6'h00;
      end else if (s2_ff[2] && clk_fall) begin
         nxt_sr = {s2_ff[1], sr_ff[36:1]};
         if (cnt_ff != 6'h3f) begin
            nxt_cnt = cnt_ff + 6'h01;
         end
      end
      if (gate_fall && cnt_ff == 6'(CMD_BITS)) begin
         nxt_done = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         sr_ff   <= 37'h0;
         cnt_ff  <= 6'h00;
         done_ff <= 1'b0;
      end else begin
         sr_ff   <= nxt_sr;
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign lnk.word = sr_ff;
   assign lnk.done = done_ff;
endmodule

// File: hdl/tvc_pulse_timer.sv
// timed pulse gate for one thruster class
`timescale 1ns/1ps
module tvc_pulse_timer #(
   parameter int CYC = 10000000
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic mode,
   output logic      gate
);
   localparam int W = $clog2(CYC + 1);
   logic [W-1:0] cnt_ff, nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (start) begin
         nxt_cnt = W'(CYC);
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign gate = ~mode | (cnt_ff != '0);
endmodule

// File: hdl/tvc_thruster_valve_ctrl.sv
// engine and latch valve command logic, top level
`timescale 1ns/1ps
module tvc_thruster_valve_ctrl
   import tvc_pkg::*;
#(
   parameter int SMALL_PULSE_CYC = PULSE_CYC,
   parameter int LARGE_PULSE_CYC = PULSE_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        link_clk,
   input  wire logic        link_data,
   input  wire logic        link_gate,
   input  wire logic        torque_req_pitch_pos,
   input  wire logic        torque_req_pitch_neg,
   input  wire logic        torque_req_yaw_pos,
   input  wire logic        torque_req_yaw_neg,
   input  wire logic        torque_req_roll_pos,
   input  wire logic        torque_req_roll_neg,
   input  wire logic        sec_alt_sel,
   input  wire logic        precession,
   input  wire logic        nutation,
   output logic [11:0]      engine_drive,
   output logic [6:0]       valve_open,
   output logic             primary_mode,
   output logic             accel_sel,
   output logic             phase_invert,
   output logic             large_jet_pulse_mode,
   output logic             small_jet_pulse_sel
);
   tvc_link_if lnk ();

   logic [11:0] tc_ff, nxt_tc;
   logic [11:0] en_ff, nxt_en;
   logic [6:0]  valve_ff, nxt_valve;
   logic        lpm_ff, nxt_lpm;
   logic        prim_ff, nxt_prim;
   logic        acc_ff, nxt_acc;
   logic        inv_ff, nxt_inv;
   logic        spm_ff, nxt_spm;
   logic [11:0] eng_ff, nxt_eng;
   logic [11:0] req_raw, req_blk;
   logic        small_jet_gate, large_jet_gate;

   ////////////////////////////////////////////////////////////////////
   // serial receiver and pulse gates
   tvc_serial_rx u_rx (
      .clock     (clock),
      .rst       (rst),
      .link_clk  (link_clk),
      .link_data (link_data),
      .link_gate (link_gate),
      .lnk       (lnk.rx)
   );

   tvc_pulse_timer #(.CYC(SMALL_PULSE_CYC)) u_small (
      .clock (clock),
      .rst   (rst),
      .start (lnk.done),
      .mode  (spm_ff),
      .gate  (small_jet_gate)
   );

   tvc_pulse_timer #(.CYC(LARGE_PULSE_CYC)) u_large (
      .clock (clock),
      .rst   (rst),
      .start (lnk.done),
      .mode  (lpm_ff),
      .gate  (large_jet_gate)
   );

   ////////////////////////////////////////////////////////////////////
   // command word holding registers
   always_comb begin
      nxt_tc    = tc_ff;
      nxt_en    = en_ff;
      nxt_valve = valve_ff;
      nxt_lpm   = lpm_ff;
      nxt_prim  = prim_ff;
      nxt_acc   = acc_ff;
      nxt_inv   = inv_ff;
      nxt_spm   = spm_ff;
      if (lnk.done) begin
         nxt_tc = lnk.word[TC_LSB +: NUM_ENG];
         if (lnk.word[XFER_BIT]) begin
            nxt_en    = lnk.word[EN_LSB +: NUM_ENG];
            nxt_valve = lnk.word[VALVE_LSB +: NUM_VALVE];
            nxt_lpm   = lnk.word[LARGE_PULSE_BIT];
            nxt_prim  = lnk.word[PRIMARY_BIT];
            nxt_acc   = lnk.word[ACCEL_BIT];
            nxt_inv   = lnk.word[PHASE_BIT];
            nxt_spm   = lnk.word[SMALL_PULSE_BIT];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tc_ff    <= 12'h000;
         en_ff    <= 12'h000;
         valve_ff <= 7'h00;
         lpm_ff   <= 1'b0;
         prim_ff  <= 1'b0;
         acc_ff   <= 1'b0;
         inv_ff   <= 1'b0;
         spm_ff   <= 1'b0;
      end else begin
         tc_ff    <= nxt_tc;
         en_ff    <= nxt_en;
         valve_ff <= nxt_valve;
         lpm_ff   <= nxt_lpm;
         prim_ff  <= nxt_prim;
         acc_ff   <= nxt_acc;
         inv_ff   <= nxt_inv;
         spm_ff   <= nxt_spm;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // axis torque requests to engines; bit n-1 is engine n
   always_comb begin
      req_raw = 12'h000;
      if (prim_ff) begin
         if (torque_req_pitch_pos) begin
            req_raw[2] = 1'b1;
            req_raw[6] = 1'b1;
         end
         if (torque_req_pitch_neg) begin
            req_raw[0] = 1'b1;
            req_raw[8] = 1'b1;
         end
         if (torque_req_yaw_pos) begin
            req_raw[5] = 1'b1;
            req_raw[9] = 1'b1;
         end
         if (torque_req_yaw_neg) begin
            req_raw[3]  = 1'b1;
            req_raw[11] = 1'b1;
         end
         if (torque_req_roll_pos) begin
            req_raw[3] = 1'b1;
            req_raw[9] = 1'b1;
         end
         if (torque_req_roll_neg) begin
            req_raw[5]  = 1'b1;
            req_raw[11] = 1'b1;
         end
      end else begin
         if (torque_req_pitch_pos) begin
            req_raw[sec_alt_sel ? 6 : 2] = 1'b1;
         end
         if (torque_req_pitch_neg) begin
            req_raw[sec_alt_sel ? 8 : 0] = 1'b1;
         end
         if (torque_req_yaw_pos) begin
            req_raw[sec_alt_sel ? 9 : 5] = 1'b1;
         end
         if (torque_req_yaw_neg) begin
            req_raw[sec_alt_sel ? 11 : 3] = 1'b1;
         end
         if (torque_req_roll_pos) begin
            req_raw[0] = 1'b1;
            req_raw[6] = 1'b1;
         end
         if (torque_req_roll_neg) begin
            req_raw[2] = 1'b1;
            req_raw[8] = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // opposing pairs 1/3, 7/9, 4/6, 10/12 cancel each other
   always_comb begin
      req_blk = req_raw;
      if (req_raw[0] && req_raw[2]) begin
         req_blk[0] = 1'b0;
         req_blk[2] = 1'b0;
      end
      if (req_raw[6] && req_raw[8]) begin
         req_blk[6] = 1'b0;
         req_blk[8] = 1'b0;
      end
      if (req_raw[3] && req_raw[5]) begin
         req_blk[3] = 1'b0;
         req_blk[5] = 1'b0;
      end
      if (req_raw[9] && req_raw[11]) begin
         req_blk[9]  = 1'b0;
         req_blk[11] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // engine drive equations
   always_comb begin
      nxt_eng = 12'h000;
      for (int i = 0; i < NUM_ENG; i++) begin
         if (!LARGE_ENG_MASK[i]) begin
            nxt_eng[i] = (req_blk[i] | tc_ff[i]) & en_ff[i]
                         & small_jet_gate;
         end else if (PN_ENG_MASK[i]) begin
            nxt_eng[i] = (precession | nutation | tc_ff[i]) & en_ff[i]
                         & large_jet_gate;
         end else begin
            nxt_eng[i] = tc_ff[i] & en_ff[i] & large_jet_gate;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         eng_ff <= 12'h000;
      end else begin
         eng_ff <= nxt_eng;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign engine_drive         = eng_ff;
   assign valve_open           = valve_ff;
   assign primary_mode         = prim_ff;
   assign accel_sel            = acc_ff;
   assign phase_invert         = inv_ff;
   assign large_jet_pulse_mode = lpm_ff;
   assign small_jet_pulse_sel  = spm_ff;
endmodule

// File: test/tvc_asserts.sv
// assertions on the thruster and valve command logic ports
`timescale 1ns/1ps
module tvc_asserts #(
   parameter int LARGE_PULSE_CYC = 50
) (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        link_gate,
   input wire logic        torque_req_pitch_pos,
   input wire logic        torque_req_pitch_neg,
   input wire logic        torque_req_roll_pos,
   input wire logic        torque_req_roll_neg,
   input wire logic        precession,
   input wire logic        nutation,
   input wire logic [11:0] engine_drive,
   input wire logic [6:0]  valve_open,
   input wire logic        primary_mode,
   input wire logic        accel_sel,
   input wire logic        phase_invert,
   input wire logic        large_jet_pulse_mode,
   input wire logic        small_jet_pulse_sel
);
   logic [3:0] fall_ff;
   logic [3:0] nxt_fall;
   logic [7:0] hi_ff;
   logic [7:0] nxt_hi;
   logic [4:0] st;
   logic       win;
   assign st = {small_jet_pulse_sel, phase_invert, accel_sel,
                primary_mode, large_jet_pulse_mode};
   assign win = fall_ff >= 4'h2 && fall_ff <= 4'h9;
   always_comb begin
      nxt_fall = link_gate ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hf};
      nxt_hi = (engine_drive[1] && !link_gate) ?
               hi_ff + {7'h00, hi_ff != 8'hff} : 8'h00;
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         fall_ff <= 4'hf;
         hi_ff <= 8'h00;
      end else begin
         fall_ff <= nxt_fall;
         hi_ff <= nxt_hi;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_rst_clear: assert property ($fell(rst) |-> engine_drive == 12'h000
      && valve_open == 7'h00 && st == 5'h00) else $error("not cleared");
   a_valve_frame: assert property ($changed(valve_open) |-> win)
      else $error("valve change outside frame");
   a_status_frame: assert property ($changed(st) |-> win)
      else $error("status change outside frame");
   a_large_cmd: assert property ($rose(engine_drive[1])
      || $rose(engine_drive[7]) |-> win) else $error("engine 2/8 rose");
   a_pn_cause: assert property ($rose(engine_drive[4]) |-> win
      || $past(precession || nutation)) else $error("engine 5 rose");
   a_eng1_cause: assert property ($rose(engine_drive[0]) |-> win
      || $past(torque_req_pitch_neg || torque_req_roll_pos))
      else $error("engine 1 rose");
   a_eng3_cause: assert property ($rose(engine_drive[2]) |-> win
      || $past(torque_req_pitch_pos || torque_req_roll_neg))
      else $error("engine 3 rose");
   a_pulse_width: assert property (large_jet_pulse_mode |->
      hi_ff <= LARGE_PULSE_CYC + 1) else $error("large pulse too long");
   c_pulse: cover property (large_jet_pulse_mode && engine_drive[1]);
   c_pn: cover property ($rose(engine_drive[4]));
   c_valve: cover property ($changed(valve_open));
endmodule
bind tvc_thruster_valve_ctrl tvc_asserts #(
   .LARGE_PULSE_CYC(LARGE_PULSE_CYC)) chk_u (.clock, .rst, .link_gate,
   .torque_req_pitch_pos, .torque_req_pitch_neg, .torque_req_roll_pos,
   .torque_req_roll_neg, .precession, .nutation, .engine_drive,
   .valve_open, .primary_mode, .accel_sel, .phase_invert,
   .large_jet_pulse_mode, .small_jet_pulse_sel);

// File: test/tvc_cmd_src.sv
// serial command word source on the far side of the link
`timescale 1ns/1ps
module tvc_cmd_src (
   output logic link_clk,
   output logic link_data,
   output logic link_gate
);
   initial begin
      link_clk = 1'b0;
      link_data = 1'b0;
      link_gate = 1'b0;
   end
   // clock still outside frames, data inverted once released
   task automatic send(input logic [36:0] w, input int n);
      // step off the system clock edge so the synchronisers never race
      #1;
      link_gate = 1'b1;
      #160;
      for (int k = 0; k < n; k++) begin
         link_clk = 1'b1;
         link_data = w[k];
         #80;
         link_clk = 1'b0;
         #80;
      end
      link_gate = 1'b0;
      link_data = ~link_data;
      #160;
   endtask
endmodule

// File: test/tb.sv
// self-checking bench for the thruster and valve command logic
`timescale 1ns/1ps
module tb;
   import tvc_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  req = 6'h00;
   logic        sec = 1'b0;
   logic        prec = 1'b0;
   logic        nut = 1'b0;
   logic        link_clk;
   logic        link_data;
   logic        link_gate;
   logic [11:0] eng;
   logic [6:0]  valve;
   logic [4:0]  st;
   int          fails = 0;
   int          total_checks = 0;
   initial forever #5 clock = ~clock;
   tvc_cmd_src src_u (.link_clk(link_clk), .link_data(link_data),
      .link_gate(link_gate));
   tvc_thruster_valve_ctrl #(.SMALL_PULSE_CYC(50),
      .LARGE_PULSE_CYC(50)) dut_u (.clock(clock), .rst(rst),
      .link_clk(link_clk), .link_data(link_data), .link_gate(link_gate),
      .torque_req_pitch_pos(req[5]), .torque_req_pitch_neg(req[4]),
      .torque_req_yaw_pos(req[3]), .torque_req_yaw_neg(req[2]),
      .torque_req_roll_pos(req[1]), .torque_req_roll_neg(req[0]),
      .sec_alt_sel(sec), .precession(prec), .nutation(nut),
      .engine_drive(eng), .valve_open(valve), .primary_mode(st[1]),
      .accel_sel(st[2]), .phase_invert(st[3]),
      .large_jet_pulse_mode(st[0]), .small_jet_pulse_sel(st[4]));
   task automatic chk(input string nm, input logic [11:0] got,
      input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   function automatic logic [36:0] mk(logic [11:0] tc, logic x,
      logic [11:0] en, logic [6:0] v, logic [4:0] m);
      return {m, v, en, x, tc};
   endfunction
   task automatic frame(input logic [36:0] w, input int n);
      src_u.send(w, n);
      repeat (8) @(posedge clock);
   endtask
   task automatic row(input logic [5:0] r, input logic a,
      input logic [11:0] e);
      @(posedge clock);
      req <= r;
      sec <= a;
      repeat (3) @(posedge clock);
      chk("request", eng, e);
      req <= 6'h00;
   endtask
   task automatic t_frame;
      frame(mk(12'ha5c, 1'b1, 12'hff0, 7'h5a, 5'h0e), 37);
      chk("engines", eng, 12'ha50);
      chk("valves", {5'h00, valve}, 12'h05a);
      chk("status", {7'h00, st}, 12'h00e);
      frame(mk(12'h0f3, 1'b0, 12'h000, 7'h00, 5'h00), 37);
      chk("engines", eng, 12'h0f0);
      chk("valves", {5'h00, valve}, 12'h05a);
      frame(mk(12'hfff, 1'b1, 12'hfff, 7'h7f, 5'h1f), 36);
      chk("engines", eng, 12'h0f0);
      chk("status", {7'h00, st}, 12'h00e);
      $display("test frame done");
   endtask
   task automatic t_pulse;
      frame(mk(12'hfff, 1'b1, 12'hfff, 7'h01, 5'h13), 37);
      chk("engines", eng, 12'hfff);
      chk("status", {7'h00, st}, 12'h013);
      repeat (29) @(posedge clock);
      chk("engines", eng, 12'hfff);
      repeat (4) @(posedge clock);
      chk("engines", eng, 12'h000);
      frame(mk(12'h800, 1'b1, 12'hfff, 7'h00, 5'h02), 37);
      repeat (60) @(posedge clock);
      chk("engines", eng, 12'h800);
      $display("test pulse done");
   endtask
   task automatic t_req;
      frame(mk(12'h000, 1'b1, 12'hfff, 7'h00, 5'h02), 37);
      row(6'h20, 1'b0, 12'h044);
      row(6'h10, 1'b1, 12'h101);
      row(6'h08, 1'b0, 12'h220);
      row(6'h04, 1'b0, 12'h808);
      row(6'h02, 1'b0, 12'h208);
      row(6'h01, 1'b0, 12'h820);
      row(6'h30, 1'b0, 12'h000);
      row(6'h0a, 1'b0, 12'h200);
      prec <= 1'b1;
      repeat (3) @(posedge clock);
      chk("precession", eng, 12'h410);
      prec <= 1'b0;
      nut <= 1'b1;
      repeat (3) @(posedge clock);
      chk("nutation", eng, 12'h410);
      nut <= 1'b0;
      frame(mk(12'h000, 1'b1, 12'hfff, 7'h00, 5'h00), 37);
      row(6'h20, 1'b0, 12'h004);
      row(6'h20, 1'b1, 12'h040);
      row(6'h04, 1'b1, 12'h800);
      row(6'h02, 1'b0, 12'h041);
      row(6'h01, 1'b0, 12'h104);
      row(6'h22, 1'b0, 12'h040);
      $display("test requests done");
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      fails++;
      end_of_test;
   end
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      t_frame;
      t_pulse;
      t_req;
      end_of_test;
   end
endmodule
